// ===== hw/ssq_pkg.sv
// constants, register map and state type of the stop-mode clock sequencer
package ssq_pkg;
	// register byte addresses
	localparam logic [7:0] SSQ_CTRL_ADDR  = 8'h00;
	localparam logic [7:0] SSQ_STAT_ADDR  = 8'h04;
	localparam logic [7:0] SSQ_ISTAT_ADDR = 8'h08;
	localparam logic [7:0] SSQ_IMASK_ADDR = 8'h0c;
	// control register fields
	localparam int SSQ_PSTOP_BIT  = 0;
	localparam int SSQ_TICKC_BIT  = 1;
	localparam int SSQ_WDOGC_BIT  = 2;
	localparam int SSQ_CME_BIT    = 3;
	localparam int SSQ_SELF_CLOCK_MODE_ENABLE_BIT   = 4;
	localparam int SSQ_SELF_CLOCK_IRQ_ENABLE_BIT  = 5;
	localparam int SSQ_PLL_CLOCK_SELECT_BIT = 6;
	localparam int SSQ_CTRL_W     = 7;
	localparam logic [6:0] SSQ_CTRL_RST = 7'h00;
	// interrupt status fields (write one to clear)
	localparam int SSQ_IRQ_SCM_BIT  = 0;
	localparam int SSQ_IRQ_STOP_BIT = 1;
	localparam int SSQ_IRQ_WAKE_BIT = 2;
	localparam int SSQ_IRQ_W        = 3;
	localparam logic [2:0] SSQ_IRQ_RST = 3'h0;
	// clock quality check: oscillator cycles per check window
	localparam int SSQ_CHECK_CYCLES = 4096;
	// most check windows after a full-stop wake-up
	localparam int SSQ_MAX_WINDOWS  = 50;
	typedef enum logic [2:0] {
		SSQ_RUN, SSQ_SWITCH, SSQ_PLL_OFF, SSQ_CORE_OFF, SSQ_SYS_OFF,
		SSQ_PSTOP, SSQ_FSTOP, SSQ_WCHECK
	} ssq_state_t;
endpackage

// ===== hw/ssq_stop_sequencer.sv
// stop-mode clock sequencer: stop entry, pseudo/full stop, wake-up and quality checks
module ssq_stop_sequencer
	import ssq_pkg::*;
#(
	parameter int CHECK_CYCLES = SSQ_CHECK_CYCLES, // cycles per quality window
	parameter int MAX_WINDOWS  = SSQ_MAX_WINDOWS   // windows before giving up
)(
	input  wire logic        ref_clk,          // oscillator-rate clock
	input  wire logic        rst,              // synchronous reset, active high
	input  wire logic        stop_req,         // core stop request level
	input  wire logic        wake_irq,         // any other wake-up interrupt
	input  wire logic        ext_reset_n,      // external reset pin, active low
	input  wire logic        clock_lost,       // clock monitor loss indication
	input  wire logic [7:0]  reg_addr,         // register byte address
	input  wire logic [31:0] reg_wdata,        // register write data
	input  wire logic        reg_wr,           // write strobe
	input  wire logic        reg_rd,           // read strobe
	output logic      [31:0] reg_rdata,        // read data, cycle after strobe
	output logic             osc_enable,       // oscillator enable
	output logic             pll_enable,       // pll enable
	output logic             core_clk_en,      // core clock gate
	output logic             sys_clk_en,       // system clock gate
	output logic             tick_clk_en,      // periodic tick clock gate
	output logic             watchdog_clk_en,  // watchdog clock gate
	output logic             power_save_req,   // request to regulator and others
	output logic             stop_active,      // core and system clocks off, pseudo or full stop
	output logic             pll_clock_select, // system clocks on pll clock
	output logic             self_clock_mode,  // running on pll free clock
	output logic             clock_monitor_reset, // monitor reset pulse
	output logic             reset_gen_start,  // reset generator start pulse
	output logic             reset_vector_alt, // monitor reset vector selected
	output logic             irq               // level interrupt
);
	// elaboration guard: the counter widths below assume these ranges
	if (CHECK_CYCLES < 2 || CHECK_CYCLES > 65536 || MAX_WINDOWS < 1 || MAX_WINDOWS > 255)
	begin : g_bad_params
		$error("ssq_stop_sequencer: unsupported parameter values");
	end

	localparam int QW = $clog2(CHECK_CYCLES + 1);
	localparam logic [QW-1:0] Q_LAST = QW'(CHECK_CYCLES - 1);
	localparam logic [7:0]    W_LAST = 8'(MAX_WINDOWS - 1);

	ssq_state_t state_ff, nxt_state;
	logic [SSQ_CTRL_W-1:0] ctrl_ff, nxt_ctrl;
	logic [SSQ_IRQ_W-1:0]  istat_ff, nxt_istat, imask_ff, nxt_imask, ev;
	logic [QW-1:0]         qcnt_ff, nxt_qcnt;
	logic [7:0]            win_ff, nxt_win;
	logic                  scm_ff, nxt_scm, bad_ff, nxt_bad, pend_ff, nxt_pend;
	logic                  cmr_ff, nxt_cmr, rgs_ff, nxt_rgs, alt_ff, nxt_alt;
	logic                  erst_m_ff, erst_s_ff, erst_d_ff, lost_m_ff, lost_s_ff;

	// pins pass two flops before use
	// no reset here: a held rst with quiet pins flushes the chain
	always_ff @(posedge ref_clk)
	begin
		erst_m_ff <= ~ext_reset_n;
		erst_s_ff <= erst_m_ff;
		erst_d_ff <= erst_s_ff;
		lost_m_ff <= clock_lost;
		lost_s_ff <= lost_m_ff;
	end

	// decoded events and configuration
	wire ext_rst_ev = erst_s_ff & ~erst_d_ff;
	wire pseudo_stop_select      = ctrl_ff[SSQ_PSTOP_BIT];
	wire clock_monitor_enable       = ctrl_ff[SSQ_CME_BIT];
	wire self_clock_mode_enable      = ctrl_ff[SSQ_SELF_CLOCK_MODE_ENABLE_BIT];
	wire self_clock_irq_enable     = ctrl_ff[SSQ_SELF_CLOCK_IRQ_ENABLE_BIT];
	wire in_pstop  = (state_ff == SSQ_PSTOP);
	wire in_fstop  = (state_ff == SSQ_FSTOP);
	wire stopped   = in_pstop | in_fstop;
	// loss only seen while the monitor is on; full stop has it off
	wire loss      = lost_s_ff & clock_monitor_enable & ~in_fstop;
	wire q_pass    = scm_ff & ~lost_s_ff & (qcnt_ff == Q_LAST);
	wire win_end   = (state_ff == SSQ_WCHECK) & (qcnt_ff == Q_LAST);
	wire win_ok    = win_end & ~bad_ff & ~lost_s_ff;
	wire win_fail  = win_end & ~win_ok & (win_ff == W_LAST);
	// one hit per register; unmapped addresses read zero and drop writes
	wire hit_ctrl  = (reg_addr == SSQ_CTRL_ADDR);
	wire hit_stat  = (reg_addr == SSQ_STAT_ADDR);
	wire hit_istat = (reg_addr == SSQ_ISTAT_ADDR);
	wire hit_imask = (reg_addr == SSQ_IMASK_ADDR);
	wire wr_ctrl   = reg_wr & hit_ctrl;
	wire wr_istat  = reg_wr & hit_istat;
	wire wr_imask  = reg_wr & hit_imask;

	// sequencing state machine
	// external reset is handled after the case so that it overrides every state
	always_comb
	begin
		nxt_state = state_ff;
		nxt_scm   = scm_ff;
		nxt_pend  = pend_ff;
		nxt_cmr   = 1'b0;
		nxt_rgs   = 1'b0;
		nxt_alt   = alt_ff;
		ev        = '0;
		case (state_ff)
			SSQ_RUN:
				if (stop_req)
					nxt_state = SSQ_SWITCH;
			SSQ_SWITCH:
				nxt_state = SSQ_PLL_OFF;
			SSQ_PLL_OFF:
				nxt_state = SSQ_CORE_OFF;
			SSQ_CORE_OFF:
				nxt_state = SSQ_SYS_OFF;
			SSQ_SYS_OFF:
			begin
				nxt_state = pseudo_stop_select ? SSQ_PSTOP : SSQ_FSTOP;
				ev[SSQ_IRQ_STOP_BIT] = 1'b1;
			end
			SSQ_PSTOP:
				if (loss && !self_clock_mode_enable)
				begin
					nxt_state = SSQ_RUN;
					nxt_cmr   = 1'b1;
					nxt_rgs   = 1'b1;
					nxt_alt   = 1'b1;
				end
				else if (loss && !scm_ff)
				begin
					nxt_scm = 1'b1;
					ev[SSQ_IRQ_SCM_BIT] = 1'b1;
					if (self_clock_irq_enable)
						nxt_state = SSQ_RUN;
				end
				else if (wake_irq)
				begin
					nxt_state = SSQ_RUN;
					ev[SSQ_IRQ_WAKE_BIT] = 1'b1;
				end
				else if (q_pass)
					nxt_scm = 1'b0;
			SSQ_FSTOP:
				if (wake_irq)
				begin
					nxt_state = SSQ_WCHECK;
					ev[SSQ_IRQ_WAKE_BIT] = 1'b1;
				end
			SSQ_WCHECK:
				if (win_ok)
				begin
					nxt_state = SSQ_RUN;
					nxt_scm   = 1'b0;
					nxt_rgs   = pend_ff;
					nxt_pend  = 1'b0;
				end
				else if (win_fail)
				begin
					nxt_state = SSQ_RUN;
					nxt_pend  = 1'b0;
					nxt_scm   = self_clock_mode_enable;
					nxt_cmr   = ~self_clock_mode_enable;
					nxt_rgs   = ~self_clock_mode_enable | pend_ff;
					nxt_alt   = ~self_clock_mode_enable;
				end
			default:
				nxt_state = SSQ_RUN;
		endcase
		// self-clock mode in run ends when a check passes
		if (state_ff == SSQ_RUN && q_pass)
			nxt_scm = 1'b0;
		// external reset overrides state, alt, pend and reset start; a monitor reset set above still fires
		if (ext_rst_ev)
		begin
			nxt_alt = 1'b0;
			if (in_fstop || state_ff == SSQ_WCHECK)
			begin
				nxt_state = SSQ_WCHECK;
				nxt_pend  = 1'b1;
				nxt_rgs   = 1'b0;
			end
			else
			begin
				nxt_state = SSQ_RUN;
				nxt_rgs   = 1'b1;
			end
		end
	end

	// quality check counter: counts clean cycles, aborted in full stop
	always_comb
	begin
		nxt_qcnt = qcnt_ff;
		nxt_win  = win_ff;
		nxt_bad  = bad_ff;
		if (state_ff == SSQ_WCHECK)
		begin
			nxt_bad  = bad_ff | lost_s_ff;
			nxt_qcnt = win_end ? '0 : qcnt_ff + 1'b1;
			if (win_end)
			begin
				nxt_bad = 1'b0;
				nxt_win = win_ff + 8'd1;
			end
		end
		else if (in_fstop || !scm_ff || lost_s_ff)
		begin
			nxt_qcnt = '0;
			nxt_win  = 8'd0;
			nxt_bad  = 1'b0;
		end
		else
			nxt_qcnt = q_pass ? '0 : qcnt_ff + 1'b1;
	end

	// configuration: hardware clears pll select on stop entry
	always_comb
	begin
		nxt_ctrl = ctrl_ff;
		if (wr_ctrl)
			nxt_ctrl = reg_wdata[SSQ_CTRL_W-1:0];
		// cleared as the request is taken, so the select is off a cycle before
		// the pll drops; a write of the select is refused until run returns
		if (nxt_state != SSQ_RUN)
			nxt_ctrl[SSQ_PLL_CLOCK_SELECT_BIT] = 1'b0;
		if (erst_s_ff)
			nxt_ctrl = SSQ_CTRL_RST;
	end

	// sticky status: a new event beats a write-one clear
	assign nxt_istat = (istat_ff & ~(wr_istat ? reg_wdata[SSQ_IRQ_W-1:0] : '0)) | ev;
	assign nxt_imask = wr_imask ? reg_wdata[SSQ_IRQ_W-1:0] : imask_ff;

	// clock gating per state; the kept-running gates let held counters resume
	// nothing here clears a counter: stop only freezes it by gating
	wire n_stop  = (nxt_state == SSQ_PSTOP) | (nxt_state == SSQ_FSTOP);
	wire n_pstop = (nxt_state == SSQ_PSTOP);
	wire n_pll   = (nxt_state == SSQ_RUN) | (nxt_state == SSQ_SWITCH) | (n_pstop & nxt_scm);
	wire n_core  = (nxt_state == SSQ_RUN) | (nxt_state == SSQ_SWITCH) |
	               (nxt_state == SSQ_PLL_OFF);
	wire n_sys   = n_core | (nxt_state == SSQ_CORE_OFF);
	wire n_osc   = ~(nxt_state == SSQ_FSTOP);
	wire n_tick  = ~n_stop | (n_pstop & nxt_ctrl[SSQ_TICKC_BIT]);
	wire n_wdog  = ~n_stop | (n_pstop & nxt_ctrl[SSQ_WDOGC_BIT]);
	// regulator stays up while self-clock checks run in pseudo-stop
	wire n_psave = n_stop & ~(n_pstop & nxt_scm);
	wire n_irq   = |(nxt_istat & nxt_imask);

	// read data mux
	wire [31:0] rd_mux =
		hit_ctrl  ? {25'h0, ctrl_ff} :
		hit_stat  ? {26'h0, pend_ff, alt_ff, scm_ff, state_ff} :
		hit_istat ? {29'h0, istat_ff} :
		hit_imask ? {29'h0, imask_ff} : 32'h0;

	// state and control registers
	// rst here and in the output flops; the counter logic clears the check counters on full stop entry
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state_ff <= SSQ_RUN;
			ctrl_ff  <= SSQ_CTRL_RST;
			istat_ff <= SSQ_IRQ_RST;
			imask_ff <= SSQ_IRQ_RST;
			qcnt_ff  <= '0;
			win_ff   <= 8'd0;
			scm_ff   <= 1'b0;
			bad_ff   <= 1'b0;
			pend_ff  <= 1'b0;
			alt_ff   <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			ctrl_ff  <= nxt_ctrl;
			istat_ff <= nxt_istat;
			imask_ff <= nxt_imask;
			qcnt_ff  <= nxt_qcnt;
			win_ff   <= nxt_win;
			scm_ff   <= nxt_scm;
			bad_ff   <= nxt_bad;
			pend_ff  <= nxt_pend;
			alt_ff   <= nxt_alt;
		end
	end

	// registered outputs
	// every output comes from a flop, so the gates never glitch downstream
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			reg_rdata           <= 32'h0;
			osc_enable          <= 1'b1;
			pll_enable          <= 1'b1;
			core_clk_en         <= 1'b1;
			sys_clk_en          <= 1'b1;
			tick_clk_en         <= 1'b1;
			watchdog_clk_en     <= 1'b1;
			power_save_req      <= 1'b0;
			stop_active         <= 1'b0;
			pll_clock_select    <= 1'b0;
			self_clock_mode     <= 1'b0;
			clock_monitor_reset <= 1'b0;
			reset_gen_start     <= 1'b0;
			reset_vector_alt    <= 1'b0;
			irq                 <= 1'b0;
		end
		else
		begin
			reg_rdata           <= reg_rd ? rd_mux : 32'h0;
			osc_enable          <= n_osc;
			pll_enable          <= n_pll;
			core_clk_en         <= n_core;
			sys_clk_en          <= n_sys;
			tick_clk_en         <= n_tick;
			watchdog_clk_en     <= n_wdog;
			power_save_req      <= n_psave;
			stop_active         <= n_stop;
			pll_clock_select    <= nxt_ctrl[SSQ_PLL_CLOCK_SELECT_BIT] | nxt_scm;
			self_clock_mode     <= nxt_scm;
			clock_monitor_reset <= nxt_cmr;
			reset_gen_start     <= nxt_rgs;
			reset_vector_alt    <= nxt_alt;
			irq                 <= n_irq;
		end
	end
endmodule

// ===== tb/ssq_checker.sv
// port-level assertions for the stop-mode clock sequencer
module ssq_checker
	import ssq_pkg::*;
#(
	parameter int CHECK_CYCLES = SSQ_CHECK_CYCLES, // cycles per window
	parameter int MAX_WINDOWS  = SSQ_MAX_WINDOWS   // window budget
)(
	input wire logic ref_clk,             // clock
	input wire logic rst,                 // sync reset
	input wire logic stop_req,            // core request
	input wire logic wake_irq,            // wake-up
	input wire logic ext_reset_n,         // reset pin
	input wire logic clock_lost,          // loss
	input wire logic osc_enable,          // oscillator
	input wire logic pll_enable,          // pll
	input wire logic core_clk_en,         // core clock
	input wire logic sys_clk_en,          // system clock
	input wire logic tick_clk_en,         // tick clock
	input wire logic watchdog_clk_en,     // watchdog clock
	input wire logic power_save_req,      // save request
	input wire logic stop_active,         // stopped
	input wire logic pll_clock_select,    // pll select
	input wire logic self_clock_mode,     // self-clock
	input wire logic clock_monitor_reset, // monitor reset
	input wire logic reset_gen_start,     // reset start
	input wire logic reset_vector_alt     // vector flag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	int quiet_ff;
	int wait_ff;
	// raw loss-free run length and full-stop wake wait; raw quiet time
	// leads the synchronised one, so the quality bound stays safe
	always_ff @(posedge ref_clk)
	begin
		quiet_ff <= (rst || clock_lost) ? 0 : quiet_ff + ((quiet_ff < CHECK_CYCLES + 4) ? 1 : 0);
		wait_ff <= (rst || core_clk_en || sys_clk_en || stop_active) ? 0 : wait_ff + 1;
	end
	sequence s_clocks_down;
		!pll_clock_select ##1 !pll_enable ##1 !core_clk_en ##1 !sys_clk_en ##1 stop_active;
	endsequence
	sequence s_resumed;
		core_clk_en && sys_clk_en && !stop_active && !pll_clock_select;
	endsequence
	a_entry_order: assert property ($rose(stop_req) && !self_clock_mode |=> s_clocks_down)
		else $error("stop entry order broken");
	a_full_off: assert property (stop_active && !osc_enable |-> !(pll_enable || core_clk_en
		|| sys_clk_en || tick_clk_en || watchdog_clk_en))
		else $error("clock left running in full stop");
	a_save_req: assert property (stop_active && !self_clock_mode |-> power_save_req
		&& !core_clk_en && !sys_clk_en)
		else $error("stop without power saving");
	a_selfclk_keep: assert property (self_clock_mode && stop_active && osc_enable |->
		pll_enable && !power_save_req)
		else $error("self-clock pseudo stop lost pll");
	a_monitor_rst: assert property (clock_monitor_reset |-> reset_gen_start
		##1 (reset_vector_alt && !clock_monitor_reset))
		else $error("monitor reset malformed");
	a_ext_reset: assert property (stop_active && osc_enable && $fell(ext_reset_n) |->
		##[1:4] (reset_gen_start ##1 !reset_vector_alt))
		else $error("external reset ignored in pseudo stop");
	a_pseudo_wake: assert property (stop_active && osc_enable && !self_clock_mode && wake_irq
		&& ext_reset_n && !clock_lost |=> s_resumed)
		else $error("pseudo stop wake wrong");
	a_quality_pass: assert property ($fell(self_clock_mode) |-> quiet_ff >= CHECK_CYCLES)
		else $error("quality check passed early");
	a_wake_bound: assert property (wait_ff <= CHECK_CYCLES * MAX_WINDOWS + 4)
		else $error("full stop wake too long");
endmodule

bind ssq_stop_sequencer ssq_checker #(
	.CHECK_CYCLES(CHECK_CYCLES),
	.MAX_WINDOWS (MAX_WINDOWS)
) ssq_checker_i (.ref_clk, .rst, .stop_req, .wake_irq, .ext_reset_n, .clock_lost,
	.osc_enable, .pll_enable, .core_clk_en, .sys_clk_en, .tick_clk_en, .watchdog_clk_en,
	.power_save_req, .stop_active, .pll_clock_select, .self_clock_mode,
	.clock_monitor_reset, .reset_gen_start, .reset_vector_alt);

// ===== tb/ssq_core_model.sv
// core-side partner: issues the stop request after its stop instruction
module ssq_core_model (
	input  wire logic ref_clk,     // clock
	input  wire logic rst,         // sync reset
	input  wire logic go,          // core executes stop
	input  wire logic stop_active, // clocks are off
	output logic      stop_req     // stop request
);
	timeunit 1ns;
	timeprecision 1ps;
	// dropped once stopped: a request still high at resume starts a new stop
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			stop_req <= 1'b0;
		else if (go)
			stop_req <= 1'b1;
		else if (stop_active)
			stop_req <= 1'b0;
	end
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the stop-mode clock sequencer
module tb_top
	import ssq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CC = 8; // shortened window
	localparam int MW = 3; // shortened budget
	logic        ref_clk, rst, go, stop_req, wake_irq, ext_reset_n, clock_lost, reg_wr;
	logic        reg_rd, osc_enable, pll_enable, core_clk_en, sys_clk_en, tick_clk_en;
	logic        watchdog_clk_en, power_save_req, stop_active, irq, pll_clock_select;
	logic        self_clock_mode, clock_monitor_reset, reset_gen_start, reset_vector_alt;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, r;
	logic [31:0] seed = 32'h00011a7f;
	logic [7:0]  addrs [5] = '{SSQ_CTRL_ADDR, SSQ_STAT_ADDR, SSQ_ISTAT_ADDR, SSQ_IMASK_ADDR, 8'h10};
	int          fail_count, comparisons, cycles, m_ctrl, m_ist, m_msk;
	ssq_stop_sequencer #(.CHECK_CYCLES(CC), .MAX_WINDOWS(MW)) ssq_stop_sequencer_i (
		.ref_clk, .rst, .stop_req, .wake_irq, .ext_reset_n, .clock_lost, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .osc_enable, .pll_enable, .core_clk_en,
		.sys_clk_en, .tick_clk_en, .watchdog_clk_en, .power_save_req, .stop_active,
		.pll_clock_select, .self_clock_mode, .clock_monitor_reset, .reset_gen_start,
		.reset_vector_alt, .irq);
	ssq_core_model ssq_core_model_i (.ref_clk, .rst, .go, .stop_active, .stop_req);
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// a hang ends the run as a failure
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			fail_count++;
			$display("mismatch at %0t: run timed out", $time);
			report_and_stop();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp, what);
		@(posedge ref_clk);
	endtask
	// bounded wait for a level, checked once it ends
	task automatic wait_lv(ref logic s, input logic v, input int lim);
		int n;
		#1;
		for (n = 0; n < lim && s !== v; n++)
		begin
			@(posedge ref_clk);
			#1;
		end
		chk(32'(s), 32'(v), "wait");
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wake();
		wake_irq <= 1'b1;
		@(posedge ref_clk);
		wake_irq <= 1'b0;
		#1;
	endtask
	// the model clears pll select on entry and notes the stop event
	task automatic enter_stop(input int ctrl);
		wr(SSQ_CTRL_ADDR, 32'(ctrl));
		m_ctrl = ctrl & 32'h3f;
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		wait_lv(stop_active, 1'b1, 12);
		m_ist |= 2;
	endtask
	initial
	begin
		rst = 1'b1;
		ext_reset_n = 1'b1;
		{go, wake_irq, clock_lost, reg_wr, reg_rd} = 5'h00;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		foreach (addrs[i])
			rd(addrs[i], 32'h0, "reset value");
		wr(8'h10, rnd());
		rd(8'h10, 32'h0, "unmapped");
		r = rnd();
		wr(SSQ_IMASK_ADDR, r);
		rd(SSQ_IMASK_ADDR, r & 32'h7, "mask");
		wr(SSQ_IMASK_ADDR, 32'h2);
		m_msk = 2;
		$display("test registers done");
		// pseudo stop with each continue bit, interrupt, wake and reselect
		for (int k = 0; k < 2; k++)
		begin
			enter_stop(32'h41 | (k ? 32'h2 : 32'h4));
			chk(32'({osc_enable, power_save_req}), 3, "osc and save");
			chk(32'({tick_clk_en, watchdog_clk_en}), k ? 2 : 1, "continue");
			rd(SSQ_CTRL_ADDR, m_ctrl, "select cleared");
			chk(32'(irq), 32'((m_ist & m_msk) != 0), "irq");
			rd(SSQ_ISTAT_ADDR, m_ist, "status");
			wr(SSQ_ISTAT_ADDR, 32'h7);
			m_ist = 0;
			chk(32'(irq), 0, "irq cleared");
			wake();
			m_ist = 4;
			chk(32'({core_clk_en, sys_clk_en, stop_active, pll_clock_select}), 12, "wake");
			rd(SSQ_CTRL_ADDR, m_ctrl, "osc clock");
			wr(SSQ_CTRL_ADDR, m_ctrl | 64);
			chk(32'({pll_clock_select, irq}), 2, "reselect, masked wake");
		end
		$display("test pseudo stop done");
		enter_stop(32'h40);
		chk(32'({osc_enable, tick_clk_en, watchdog_clk_en}), 0, "full stop");
		wake();
		wait_lv(core_clk_en, 1'b1, CC + 6);
		enter_stop(32'h08);
		clock_lost <= 1'b1;
		wake();
		wait_lv(clock_monitor_reset, 1'b1, CC * MW + 6);
		clock_lost <= 1'b0;
		$display("test full stop done");
		enter_stop(32'h01);
		ext_reset_n <= 1'b0;
		wait_lv(reset_gen_start, 1'b1, 6);
		rd(SSQ_CTRL_ADDR, 32'h0, "defaults");
		ext_reset_n <= 1'b1;
		cyc(4);
		chk(32'({core_clk_en, stop_active, reset_vector_alt}), 4, "after reset");
		enter_stop(32'h01);
		clock_lost <= 1'b1;
		cyc(5);
		clock_lost <= 1'b0;
		chk(32'({stop_active, self_clock_mode}), 2, "loss ignored");
		wake();
		wr(SSQ_ISTAT_ADDR, 32'h7);
		m_ist = 0;
		enter_stop(32'h19);
		clock_lost <= 1'b1;
		wait_lv(self_clock_mode, 1'b1, 6);
		clock_lost <= 1'b0;
		m_ist |= 1;
		chk(32'({stop_active, pll_enable}), 3, "stays stopped");
		rd(SSQ_ISTAT_ADDR, m_ist, "flag set");
		wait_lv(self_clock_mode, 1'b0, CC + 6);
		chk(32'({stop_active, power_save_req, pll_enable}), 6, "recovered");
		wake();
		enter_stop(32'h39);
		clock_lost <= 1'b1;
		wait_lv(core_clk_en, 1'b1, 8);
		clock_lost <= 1'b0;
		chk(32'({stop_active, self_clock_mode}), 1, "self-clock wake");
		wait_lv(self_clock_mode, 1'b0, CC + 8);
		enter_stop(32'h09);
		clock_lost <= 1'b1;
		wait_lv(clock_monitor_reset, 1'b1, 6);
		clock_lost <= 1'b0;
		cyc(2);
		chk(32'({reset_vector_alt, stop_active}), 2, "monitor reset");
		$display("test clock loss done");
		report_and_stop();
	end
endmodule
